// ==== logic/hdlcaf_station_filter.sv ====
/*
  Station address filter: AHB-Lite registers, transmit address selection,
  receive address/control parsing, filtering and bad frame counting.
  Assumes the receiver delivers octets and a separate end pulse, with FCS
  and alignment status valid in the end cycle, all on hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module hdlcaf_station_filter
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // receive octet stream
   input  wire logic        rx_octet_valid,
   input  wire logic [7:0]  rx_octet,
   input  wire logic        rx_frame_end,
   input  wire logic        rx_fcs_good,
   input  wire logic        rx_octet_aligned,
   // receive verdict
   output var  logic        rx_frame_accept,
   output var  logic        rx_frame_ignore,
   output var  logic        rx_frame_bad,
   output var  logic        rx_is_command,
   output var  logic        rx_matched_remote,
   output var  logic        rx_addr_two,
   output var  logic        rx_ctrl_two,
   // transmit address
   input  wire logic        tx_frame_start,
   input  wire logic        tx_frame_is_cmd,
   output var  logic [15:0] tx_address,
   output var  logic        tx_address_two,
   output var  logic        tx_address_valid
);
   import hdlcaf_pkg::*;

   // ==========================================================
   // state
   typedef struct packed
   {
      logic             wr_pend;
      logic [7:0]       wr_addr;
      logic [31:0]      hrdata;
      logic             hreadyout;
      logic             hresp;
      logic [15:0]      mode;
      logic [15:0]      second_control_status_reg;
      logic [15:0]      local_addr;
      logic [15:0]      remote_addr;
      logic [15:0]      act_local;
      logic [15:0]      act_remote;
      logic [15:0]      bad_count;
      hdlcaf_rx_state_e st;
      logic [7:0]       a0;
      logic [7:0]       a1;
      logic             addr_two;
      logic             ctrl_two;
      logic             got_addr;
      logic             frame_accept;
      logic             frame_ignore;
      logic             frame_bad;
      logic             is_cmd;
      logic             matched_remote;
      logic             out_addr_two;
      logic             out_ctrl_two;
      logic [15:0]      tx_address;
      logic             tx_two;
      logic             tx_valid;
   } hdlcaf_state_s;

   hdlcaf_state_s  r_reg;
   hdlcaf_state_s  r_next;
   hdlcaf_match_if mi ();
   logic           ext_addr;
   logic           ext_ctrl;
   logic           force_addr;
   logic           force_ctrl;
   logic           glob_acc;
   logic           accept_all;
   logic           raw_pass;
   logic           good_frame;
   logic           any_hit;
   logic           clear_bad;
   logic           inc_bad;
   logic           take;

   assign ext_addr   = r_reg.mode[MODE_EXT_ADDR_BIT];
   assign ext_ctrl   = r_reg.mode[MODE_EXT_CTRL_BIT];
   assign force_addr = r_reg.mode[MODE_FORCE_ADDR_BIT];
   assign force_ctrl = r_reg.mode[MODE_FORCE_CTRL_BIT];
   assign raw_pass   = r_reg.mode[MODE_RAW_FIELD_BIT];
   assign glob_acc   = r_reg.second_control_status_reg[SECOND_CONTROL_STATUS_REG_GLOBAL_BIT];
   assign accept_all = r_reg.second_control_status_reg[SECOND_CONTROL_STATUS_REG_ACCEPT_ALL_BIT]; // see RULE23
   assign good_frame = rx_fcs_good & rx_octet_aligned;
   assign take       = hsel & htrans[1] & hready;

   // ==========================================================
   // comparator
   assign mi.addr_lo     = r_reg.a0;
   assign mi.addr_hi     = r_reg.a1;
   assign mi.addr_two    = r_reg.addr_two;
   assign mi.ignore_lsb  = ext_addr & force_addr; // see RULE21
   assign mi.local_addr  = r_reg.local_addr;
   assign mi.remote_addr = r_reg.remote_addr;
   // see RULE16, RULE18, RULE20
   assign any_hit = r_reg.got_addr & (mi.hit_local | mi.hit_remote | (glob_acc & mi.hit_global));

   hdlcaf_addr_match u_match
   (
      .m (mi.matcher)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      r_next              = r_reg;
      r_next.frame_accept = 1'b0;
      r_next.frame_ignore = 1'b0;
      r_next.frame_bad    = 1'b0;
      clear_bad           = 1'b0;
      inc_bad             = 1'b0;
      // bus data phase
      if (r_reg.wr_pend)
      begin
         case (r_reg.wr_addr)
            OFS_MODE:   r_next.mode = hwdata[15:0] & MODE_MASK;
            OFS_SECOND_CONTROL_STATUS_REG:   r_next.second_control_status_reg = hwdata[15:0] & SECOND_CONTROL_STATUS_REG_MASK;
            OFS_LOCAL:  r_next.local_addr = hwdata[15:0];
            OFS_REMOTE: r_next.remote_addr = hwdata[15:0];
            OFS_BADCNT: clear_bad = 1'b1;
            OFS_PRIM:
            begin
               // transmit addresses only change on init, see RULE6
               if (hwdata[2:0] == PRIM_INIT)
               begin
                  r_next.act_local  = r_reg.local_addr;
                  r_next.act_remote = r_reg.remote_addr;
               end
            end
            default: r_next.wr_pend = 1'b0;
         endcase
      end
      // receive parsing and verdict
      if (rx_frame_end)
      begin
         r_next.st             = RX_ADDR0;
         r_next.got_addr       = 1'b0;
         r_next.addr_two       = 1'b0;
         r_next.ctrl_two       = 1'b0;
         r_next.out_addr_two   = r_reg.addr_two;
         r_next.out_ctrl_two   = r_reg.ctrl_two;
         r_next.is_cmd         = r_reg.got_addr & ~mi.hit_local
                                 & (mi.hit_remote | (glob_acc & mi.hit_global)); // see RULE3, RULE4, RULE5
         r_next.matched_remote = r_reg.got_addr & ~mi.hit_local & mi.hit_remote;
         if (!good_frame)
         begin
            r_next.frame_bad = 1'b1; // see RULE11
            inc_bad          = 1'b1;
         end
         else if (accept_all | any_hit)
         begin
            r_next.frame_accept = 1'b1; // see RULE17
         end
         else
         begin
            r_next.frame_ignore = 1'b1; // see RULE10
         end
      end
      else if (rx_octet_valid)
      begin
         case (r_reg.st)
            RX_ADDR0:
            begin
               r_next.a0       = rx_octet;
               r_next.a1       = 8'h00;
               // see RULE7, RULE14
               r_next.addr_two = ext_addr & (force_addr | ~rx_octet[0]);
               r_next.got_addr = ~(ext_addr & (force_addr | ~rx_octet[0]));
               r_next.st       = (ext_addr & (force_addr | ~rx_octet[0])) ? RX_ADDR1 : RX_CTRL0;
            end
            RX_ADDR1:
            begin
               r_next.a1       = rx_octet;
               r_next.got_addr = 1'b1;
               r_next.st       = RX_CTRL0;
            end
            RX_CTRL0:
            begin
               // see RULE12, RULE13, RULE15
               r_next.ctrl_two = ext_ctrl & (force_ctrl | (rx_octet[1:0] != 2'h3));
               r_next.st       = (ext_ctrl & (force_ctrl | (rx_octet[1:0] != 2'h3))) ? RX_CTRL1 : RX_INFO;
            end
            RX_CTRL1: r_next.st = RX_INFO;
            RX_INFO:  r_next.st = RX_INFO;
            default:  r_next.st = RX_ADDR0;
         endcase
      end
      // a clear and an increment in the same cycle leave the counter at one
      if (inc_bad)
      begin
         r_next.bad_count = clear_bad ? 16'h0001 : r_reg.bad_count + 16'h0001;
      end
      else if (clear_bad)
      begin
         r_next.bad_count = BADCNT_RESET;
      end
      // transmit address
      if (tx_frame_start)
      begin
         // see RULE1, RULE2
         r_next.tx_address = tx_frame_is_cmd ? r_reg.act_remote : r_reg.act_local;
         r_next.tx_two     = ext_addr & (force_addr |
                             ~(tx_frame_is_cmd ? r_reg.act_remote[0] : r_reg.act_local[0]));
         r_next.tx_valid   = 1'b1;
      end
      // bus address phase; read sees any write landing this cycle
      r_next.wr_pend = take & hwrite;
      r_next.wr_addr = haddr[7:0];
      r_next.hrdata  = 32'h0000_0000;
      if (take & ~hwrite)
      begin
         case (haddr[7:0])
            OFS_MODE:   r_next.hrdata = {16'h0000, r_next.mode};
            OFS_SECOND_CONTROL_STATUS_REG:   r_next.hrdata = {16'h0000, r_next.second_control_status_reg};
            OFS_LOCAL:  r_next.hrdata = {16'h0000, r_next.local_addr};
            OFS_REMOTE: r_next.hrdata = {16'h0000, r_next.remote_addr};
            OFS_BADCNT: r_next.hrdata = {16'h0000, r_next.bad_count};
            OFS_STATUS: r_next.hrdata = {24'h00_0000, raw_pass, r_next.st, r_next.out_ctrl_two,
                                         r_next.out_addr_two, r_next.matched_remote, r_next.is_cmd};
            default:    r_next.hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_reg             <= '0;
         r_reg.hreadyout   <= 1'b1;
         r_reg.mode        <= MODE_RESET;
         r_reg.second_control_status_reg        <= SECOND_CONTROL_STATUS_REG_RESET;
         r_reg.local_addr  <= ADDR_RESET;
         r_reg.remote_addr <= ADDR_RESET;
         r_reg.act_local   <= ADDR_RESET;
         r_reg.act_remote  <= ADDR_RESET;
         r_reg.bad_count   <= BADCNT_RESET;
         r_reg.st          <= RX_ADDR0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // outputs
   assign hrdata            = r_reg.hrdata;
   assign hreadyout         = r_reg.hreadyout;
   assign hresp             = r_reg.hresp;
   assign rx_frame_accept   = r_reg.frame_accept;
   assign rx_frame_ignore   = r_reg.frame_ignore;
   assign rx_frame_bad      = r_reg.frame_bad;
   assign rx_is_command     = r_reg.is_cmd;
   assign rx_matched_remote = r_reg.matched_remote;
   assign rx_addr_two       = r_reg.out_addr_two;
   assign rx_ctrl_two       = r_reg.out_ctrl_two;
   assign tx_address        = r_reg.tx_address;
   assign tx_address_two    = r_reg.tx_two;
   assign tx_address_valid  = r_reg.tx_valid;

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_tx_cmd_remote: assert property (tx_frame_start && tx_frame_is_cmd |=> // see RULE1
      tx_address == $past(r_reg.act_remote) && tx_address_valid) else $error("command address wrong");
   a_tx_rsp_local: assert property (tx_frame_start && !tx_frame_is_cmd |=> // see RULE2
      tx_address == $past(r_reg.act_local)) else $error("response address wrong");
   a_local_is_rsp: assert property (rx_frame_end && good_frame && r_reg.got_addr && mi.hit_local // see RULE3
      |=> rx_frame_accept && !rx_is_command) else $error("local match not a response");
   a_remote_is_cmd: assert property (rx_frame_end && good_frame && r_reg.got_addr // see RULE4
      && !mi.hit_local && mi.hit_remote |=> rx_frame_accept && rx_is_command && rx_matched_remote)
      else $error("remote match not a command");
   a_global_is_cmd: assert property (rx_frame_end && good_frame && r_reg.got_addr && glob_acc // see RULE5
      && mi.hit_global && !mi.hit_local |=> rx_frame_accept && rx_is_command)
      else $error("global frame not a command");
   a_init_loads: assert property (r_reg.wr_pend && r_reg.wr_addr == OFS_PRIM // see RULE6
      && hwdata[2:0] == PRIM_INIT |=> r_reg.act_remote == $past(r_reg.remote_addr)
      && r_reg.act_local == $past(r_reg.local_addr)) else $error("init did not load addresses");
   a_single_octet: assert property (rx_octet_valid && !rx_frame_end && r_reg.st == RX_ADDR0 // see RULE7
      && !ext_addr |=> r_reg.st == RX_CTRL0 ##0 r_reg.got_addr) else $error("single octet parse");
   a_unmatched_drop: assert property (rx_frame_end && good_frame && !accept_all && !any_hit // see RULE10
      |=> rx_frame_ignore && !rx_frame_accept) else $error("unmatched frame not ignored");
   a_bad_discard: assert property (rx_frame_end && !good_frame // see RULE11
      |=> rx_frame_bad && !rx_frame_accept && !rx_frame_ignore) else $error("bad frame not discarded");
   a_bad_count: assert property (rx_frame_end && !good_frame && !clear_bad // see RULE11
      |=> r_reg.bad_count == $past(r_reg.bad_count) + 16'h0001) else $error("bad count not bumped");
   a_ctrl_one: assert property (rx_octet_valid && !rx_frame_end && r_reg.st == RX_CTRL0 && !ext_ctrl // see RULE12
      |=> r_reg.st == RX_INFO && !r_reg.ctrl_two) else $error("control not one octet");
   a_accept_all: assert property (rx_frame_end && good_frame && accept_all // see RULE17
      |=> rx_frame_accept) else $error("accept-all frame dropped");

   c_cmd_frame: cover property (rx_frame_accept && rx_is_command);
   c_rsp_frame: cover property (rx_frame_accept && !rx_is_command);
   c_ignored: cover property (rx_frame_ignore);
   c_bad: cover property (rx_frame_bad);
endmodule
`default_nettype wire

// ==== logic/hdlcaf_pkg.sv ====
/*
  Constants for the station address filter: register offsets, field
  positions, reset values and the receive parser states.
  Assumes an AHB-Lite slave decoding the low byte of haddr.
*/
// Summary of operation
// RULE1: commands carry the remote station address
// RULE2: responses carry the local station address
// RULE3: local address match means response
// RULE4: remote address match means command
// RULE5: global accept takes all-ones as command
// RULE6: global sent only when loaded before init
// RULE7: extended select chooses one or two octets
// RULE8: host keeps single addresses in low byte
// RULE9: host clears address bit zero when extended
// RULE10: unmatched frames are silently ignored
// RULE11: bad or misaligned frames discarded and counted
// RULE12: control field one octet unless extended
// RULE13: extended control two octets unless low bits ones
// RULE14: forced address takes two bytes always
// RULE15: forced control takes two bytes always
// RULE16: plain mode filters one octet, both addresses
// RULE17: accept-all with raw field accepts everything
// RULE18: single octet plus global accepts three addresses
// RULE19: host avoids raw field without accept-all
// RULE20: extended unforced filters two octets, raw ignored
// RULE21: extended forced ignores address least bit
// RULE22: host sets raw and accept-all only transparently
// RULE23: accept-all lives in second control bit ten
`default_nettype none
package hdlcaf_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_MODE    = 8'h00;
   localparam logic [7:0] OFS_SECOND_CONTROL_STATUS_REG    = 8'h04;
   localparam logic [7:0] OFS_LOCAL   = 8'h08;
   localparam logic [7:0] OFS_REMOTE  = 8'h0c;
   localparam logic [7:0] OFS_BADCNT  = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_PRIM    = 8'h18;
   // ==========================================================
   // field positions
   localparam int MODE_EXT_ADDR_BIT    = 6;
   localparam int MODE_EXT_CTRL_BIT    = 7;
   localparam int MODE_FORCE_ADDR_BIT  = 9;
   localparam int MODE_FORCE_CTRL_BIT  = 10;
   localparam int MODE_RAW_FIELD_BIT   = 11;
   localparam int SECOND_CONTROL_STATUS_REG_GLOBAL_BIT      = 8;
   localparam int SECOND_CONTROL_STATUS_REG_ACCEPT_ALL_BIT  = 10;
   localparam logic [15:0] MODE_MASK   = 16'h0ec0;
   localparam logic [15:0] SECOND_CONTROL_STATUS_REG_MASK   = 16'h0500;
   // ==========================================================
   // values and reset values
   localparam logic [2:0]  PRIM_INIT     = 3'h2;
   localparam logic [15:0] GLOBAL_WORD   = 16'hffff;
   localparam logic [15:0] MODE_RESET    = 16'h0000;
   localparam logic [15:0] SECOND_CONTROL_STATUS_REG_RESET    = 16'h0000;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;
   localparam logic [15:0] BADCNT_RESET  = 16'h0000;
   // ==========================================================
   // receive parser, gray along the two-octet address and control path
   typedef enum logic [2:0]
   {
      RX_ADDR0 = 3'h0,
      RX_ADDR1 = 3'h1,
      RX_CTRL0 = 3'h3,
      RX_CTRL1 = 3'h2,
      RX_INFO  = 3'h6
   } hdlcaf_rx_state_e;
endpackage
`default_nettype wire

// ==== logic/hdlcaf_match_if.sv ====
/*
  Carrier between the filter and its address comparator.
  Assumes the comparator is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface hdlcaf_match_if;
   logic [7:0]  addr_lo;
   logic [7:0]  addr_hi;
   logic        addr_two;
   logic        ignore_lsb;
   logic [15:0] local_addr;
   logic [15:0] remote_addr;
   logic        hit_local;
   logic        hit_remote;
   logic        hit_global;
   modport requester (output addr_lo, addr_hi, addr_two, ignore_lsb, local_addr, remote_addr,
                      input hit_local, hit_remote, hit_global);
   modport matcher (input addr_lo, addr_hi, addr_two, ignore_lsb, local_addr, remote_addr,
                    output hit_local, hit_remote, hit_global);
endinterface
`default_nettype wire

// ==== logic/hdlcaf_addr_match.sv ====
/*
  Address comparator: received address against local, remote and global.
  Assumes first received octet sits in the low byte of each station word.
*/
`timescale 1ns/10ps
`default_nettype none
module hdlcaf_addr_match
(
   // comparator side of the carrier
   hdlcaf_match_if.matcher m
);
   import hdlcaf_pkg::*;
   logic [15:0] mask;
   logic [15:0] rx_word;
   always_comb
   begin
      // one octet compares the low byte only, see RULE8
      mask = m.addr_two ? 16'hffff : 16'h00ff;
      if (m.ignore_lsb)
      begin
         mask[0] = 1'b0; // see RULE21
      end
      rx_word      = {m.addr_hi, m.addr_lo};
      m.hit_local  = ((rx_word ^ m.local_addr) & mask) == 16'h0000;  // see RULE3
      m.hit_remote = ((rx_word ^ m.remote_addr) & mask) == 16'h0000; // see RULE4
      m.hit_global = ((rx_word ^ GLOBAL_WORD) & mask) == 16'h0000;   // see RULE5
   end
endmodule
`default_nettype wire

// ==== verif/hdlcaf_remote_station.sv ====
/*
  Remote station model: hands octet frames to the filter's receive side.
  Assumes the bench calls send() and supplies hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module hdlcaf_remote_station
(
   // clock
   input  wire logic       hclk,
   // octet stream toward the filter
   output var  logic       rx_octet_valid,
   output var  logic [7:0] rx_octet,
   output var  logic       rx_frame_end,
   output var  logic       rx_fcs_good,
   output var  logic       rx_octet_aligned
);
   logic busy = 1'b0;
   initial
   begin
      rx_octet_valid   = 1'b0;
      rx_octet         = 8'h5a;
      rx_frame_end     = 1'b0;
      rx_fcs_good      = 1'b0;
      rx_octet_aligned = 1'b1;
   end
   // =========================================
   // idle: lines carry no stale value
   always @(posedge hclk)
   begin
      if (!busy)
      begin
         rx_octet         <= ~rx_octet;
         rx_fcs_good      <= ~rx_fcs_good;
         rx_octet_aligned <= ~rx_octet_aligned;
      end
   end
   // =========================================
   // one frame, then end pulse with status
   task send(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n,
             input logic [1:0] st);
      logic [7:0] o [3];
      o = '{a, b, c};
      busy = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge hclk);
         rx_octet_valid <= 1'b1;
         rx_octet       <= o[i];
      end
      @(posedge hclk);
      rx_octet_valid   <= 1'b0;
      rx_octet         <= ~o[n-1];
      rx_frame_end     <= 1'b1;
      rx_fcs_good      <= st[1];
      rx_octet_aligned <= st[0];
      @(posedge hclk);
      rx_frame_end <= 1'b0;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verif/test_hdlc_station_address_filter.sv ====
/*
  Self-checking bench for the station address filter.
  Assumes the design answers AHB-Lite with zero wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_station_address_filter;
   import hdlcaf_pkg::*;
   localparam logic [2:0] ACC = 3'b100;
   localparam logic [2:0] IGN = 3'b010;
   localparam logic [2:0] BAD = 3'b001;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic        hready;
   logic [31:0] hrdata, scratch;
   logic        hreadyout, hresp, rx_octet_valid, rx_frame_end, rx_fcs_good, rx_octet_aligned;
   logic [7:0]  rx_octet;
   logic        rx_frame_accept, rx_frame_ignore, rx_frame_bad, rx_is_command, rx_matched_remote;
   logic        rx_addr_two, rx_ctrl_two, tx_address_two, tx_address_valid;
   logic        tx_frame_start = 1'b0;
   logic        tx_frame_is_cmd = 1'b0;
   logic [15:0] tx_address;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   hdlcaf_station_filter dut_u
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rx_octet_valid(rx_octet_valid), .rx_octet(rx_octet), .rx_frame_end(rx_frame_end),
      .rx_fcs_good(rx_fcs_good), .rx_octet_aligned(rx_octet_aligned), .rx_frame_accept(rx_frame_accept),
      .rx_frame_ignore(rx_frame_ignore), .rx_frame_bad(rx_frame_bad), .rx_is_command(rx_is_command),
      .rx_matched_remote(rx_matched_remote), .rx_addr_two(rx_addr_two), .rx_ctrl_two(rx_ctrl_two),
      .tx_frame_start(tx_frame_start), .tx_frame_is_cmd(tx_frame_is_cmd), .tx_address(tx_address),
      .tx_address_two(tx_address_two), .tx_address_valid(tx_address_valid)
   );
   hdlcaf_remote_station partner_u
   (
      .hclk(hclk), .rx_octet_valid(rx_octet_valid), .rx_octet(rx_octet), .rx_frame_end(rx_frame_end),
      .rx_fcs_good(rx_fcs_good), .rx_octet_aligned(rx_octet_aligned)
   );
   // =========================================
   // shared tasks
   task conclude;
      if (bad_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, scratch);
   endtask
   task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000, scratch);
      chk(name, scratch, exp);
   endtask
   task tx(input logic cmd, input logic [15:0] exp);
      @(posedge hclk);
      tx_frame_start  <= 1'b1;
      tx_frame_is_cmd <= cmd;
      @(posedge hclk);
      tx_frame_start <= 1'b0;
      #1 chk("tx_address", {16'h0000, tx_address}, {16'h0000, exp});
   endtask
   // class: is_command, matched_remote, addr_two, ctrl_two
   task frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n,
              input logic [1:0] st, input logic [2:0] v, input logic [3:0] cl);
      partner_u.send(a, b, c, n, st);
      #1 chk("verdict", {rx_frame_accept, rx_frame_ignore, rx_frame_bad}, v);
      if (v == ACC)
         chk("class", {rx_is_command, rx_matched_remote, rx_addr_two, rx_ctrl_two}, cl);
   endtask
   // =========================================
   // scenarios
   task t_reset;
      chk("hreadyout", hreadyout, 1'b1);
      chk("hresp", hresp, 1'b0);
      chk("tx_valid", tx_address_valid, 1'b0);
      rd("mode", OFS_MODE, {16'h0000, MODE_RESET});
      rd("second_control_status_reg", OFS_SECOND_CONTROL_STATUS_REG, {16'h0000, SECOND_CONTROL_STATUS_REG_RESET});
      rd("local", OFS_LOCAL, {16'h0000, ADDR_RESET});
      rd("remote", OFS_REMOTE, {16'h0000, ADDR_RESET});
      rd("badcnt", OFS_BADCNT, {16'h0000, BADCNT_RESET});
      wr(OFS_STATUS, 32'hffff_ffff);
      rd("status", OFS_STATUS, 32'h0000_0000);
      rd("unmapped", 8'h1c, 32'h0000_0000);
   endtask
   task t_tx;
      wr(OFS_LOCAL, 32'h0000_0012);
      wr(OFS_REMOTE, 32'h0000_0034);
      tx(1'b1, 16'h0000);
      wr(OFS_PRIM, {29'h0, PRIM_INIT});
      tx(1'b1, 16'h0034);
      tx(1'b0, 16'h0012);
      chk("tx_valid", tx_address_valid, 1'b1);
      chk("tx_two", tx_address_two, 1'b0);
      wr(OFS_LOCAL, {16'h0000, GLOBAL_WORD});
      tx(1'b0, 16'h0012);
      wr(OFS_PRIM, {29'h0, PRIM_INIT});
      tx(1'b0, GLOBAL_WORD);
      wr(OFS_LOCAL, 32'h0000_0012);
   endtask
   task t_single;
      frame(8'h12, 8'h00, 8'h00, 2, 2'b11, ACC, 4'b0000);
      frame(8'h34, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b1100);
      rd("status", OFS_STATUS, 32'h0000_0003);
      frame(8'h56, 8'h03, 8'h00, 2, 2'b11, IGN, 4'b0000);
      frame(8'hff, 8'h03, 8'h00, 2, 2'b11, IGN, 4'b0000);
      wr(OFS_SECOND_CONTROL_STATUS_REG, 32'h1 << SECOND_CONTROL_STATUS_REG_GLOBAL_BIT);
      frame(8'hff, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b1000);
      frame(8'h12, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b0000);
      frame(8'h56, 8'h03, 8'h00, 2, 2'b11, IGN, 4'b0000);
      wr(OFS_SECOND_CONTROL_STATUS_REG, 32'h0000_0000);
   endtask
   task t_bad;
      frame(8'h12, 8'h03, 8'h00, 2, 2'b01, BAD, 4'b0000);
      frame(8'h56, 8'h03, 8'h00, 2, 2'b10, BAD, 4'b0000);
      rd("badcnt", OFS_BADCNT, 32'h0000_0002);
      wr(OFS_BADCNT, 32'h0000_0000);
      rd("badcnt", OFS_BADCNT, 32'h0000_0000);
   endtask
   task t_ext;
      wr(OFS_LOCAL, 32'h0000_3412);
      wr(OFS_MODE, 32'h1 << MODE_EXT_ADDR_BIT);
      tx(1'b1, 16'h0034);
      chk("tx_two", tx_address_two, 1'b1);
      tx(1'b0, GLOBAL_WORD);
      chk("tx_two", tx_address_two, 1'b0);
      frame(8'h12, 8'h34, 8'h03, 3, 2'b11, ACC, 4'b0010);
      frame(8'h34, 8'h00, 8'h03, 3, 2'b11, ACC, 4'b1110);
      frame(8'h13, 8'h03, 8'h00, 2, 2'b11, IGN, 4'b0000);
      wr(OFS_MODE, (32'h1 << MODE_EXT_ADDR_BIT) | (32'h1 << MODE_RAW_FIELD_BIT));
      frame(8'h12, 8'h34, 8'h03, 3, 2'b11, ACC, 4'b0010);
      wr(OFS_MODE, (32'h1 << MODE_EXT_ADDR_BIT) | (32'h1 << MODE_FORCE_ADDR_BIT));
      frame(8'h13, 8'h34, 8'h03, 3, 2'b11, ACC, 4'b0010);
      wr(OFS_MODE, 32'h1 << MODE_EXT_CTRL_BIT);
      frame(8'h12, 8'h00, 8'h00, 3, 2'b11, ACC, 4'b0001);
      frame(8'h12, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b0000);
      wr(OFS_MODE, (32'h1 << MODE_EXT_CTRL_BIT) | (32'h1 << MODE_FORCE_CTRL_BIT));
      rd("mode", OFS_MODE, 32'h0000_0480);
      frame(8'h12, 8'h03, 8'h00, 3, 2'b11, ACC, 4'b0001);
      wr(OFS_MODE, 32'h1 << MODE_FORCE_CTRL_BIT);
      frame(8'h12, 8'h00, 8'h00, 2, 2'b11, ACC, 4'b0000);
   endtask
   task t_all;
      // raw field only together with accept-all
      wr(OFS_SECOND_CONTROL_STATUS_REG, 32'h1 << SECOND_CONTROL_STATUS_REG_ACCEPT_ALL_BIT);
      wr(OFS_MODE, 32'h1 << MODE_RAW_FIELD_BIT);
      rd("second_control_status_reg", OFS_SECOND_CONTROL_STATUS_REG, 32'h0000_0400);
      frame(8'h56, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b0000);
      frame(8'hff, 8'h03, 8'h00, 2, 2'b11, ACC, 4'b0000);
      wr(OFS_MODE, 32'h0000_0000);
      wr(OFS_SECOND_CONTROL_STATUS_REG, 32'h0000_0000);
   endtask
   // =========================================
   // main sequence and hang guard
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      t_reset();
      t_tx();
      t_single();
      t_bad();
      t_ext();
      t_all();
      conclude();
   end
endmodule
`default_nettype wire
